// file: verilog/ccm_pkg.sv
package ccm_pkg;
  // Card families served by the reader
  typedef enum logic [2:0] {
    CARD_STD = 3'h0, CARD_LARGE = 3'h1, CARD_PLAIN = 3'h2, CARD_OS = 3'h3, CARD_APP = 3'h4
  } ccm_card_e;

  // Request codes, forwarded to the card front end as its operation except CMD_STORE_KEY; value commands go as CMD_READ or CMD_WRITE
  typedef enum logic [3:0] {
    CMD_READ = 4'h0, CMD_WRITE = 4'h1, CMD_READ_VALUE = 4'h2, CMD_WRITE_VALUE = 4'h3,
    CMD_STORE_KEY = 4'h4, CMD_SELECT = 4'h5, CMD_ACTIVATE = 4'h6, CMD_SELECT_APP = 4'h7,
    CMD_SELECT_FILE = 4'h8, CMD_LOGIN = 4'h9, CMD_CHANGE_FILE = 4'ha, CMD_COMMIT = 4'hb,
    CMD_ABORT = 4'hc, CMD_TRANSFER = 4'hd
  } ccm_cmd_e;

  typedef enum logic [3:0] {
    ERR_NONE = 4'h0, ERR_RANGE = 4'h1, ERR_READ_ONLY = 4'h2, ERR_NOT_SELECTED = 4'h3,
    ERR_NO_LOGIN = 4'h4, ERR_VALUE = 4'h5, ERR_CARD = 4'h6, ERR_COMMAND = 4'h7
  } ccm_err_e;

  // File protection modes of application cards
  typedef enum logic [1:0] {
    PROT_PLAIN = 2'h0, PROT_MAC = 2'h1, PROT_DES = 2'h2, PROT_TDES = 2'h3
  } ccm_prot_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_RESP = 2'b10
  } ccm_state_e;

  localparam logic [7:0] STD_SECTORS = 8'h10;
  localparam logic [3:0] SMALL_BLOCKS = 4'h3;
  localparam logic [7:0] BIG_FIRST = 8'h20;
  localparam logic [7:0] BIG_LAST = 8'h27;
  localparam logic [7:0] BIG_BLOCK_BASE = 8'h80;
  localparam logic [3:0] BIG_BLOCKS = 4'hf;
  localparam logic [7:0] PLAIN_PAGES = 8'hff;
  localparam int KEY_SLOTS = 32;
  localparam logic [5:0] VOLATILE_SLOT = 6'h20;
  localparam logic [7:0] MAX_APPS = 8'h1c;
  localparam logic [3:0] MAX_FILES = 4'hf;
  localparam logic [5:0] MAX_KEYS = 6'h0e;
  localparam logic [23:0] ACCESS_DELIVERY = 24'hff0780;
  localparam int KEY_A_LSB = 80;
  localparam int ACCESS_LSB = 56;
  localparam int KEY_B_LSB = 0;
  localparam int PLAIN_BITS = 32;
  localparam int UID_BITS = 56;
endpackage : ccm_pkg

// file: verilog/ccm_card_memory.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Standard card: sixteen sectors of four sixteen-byte blocks.
// - Thirty-two stored six-byte keys plus one volatile key.
// - Block zero of sector zero is never written.
// - Trailer block is key one, four access bytes, key two.
// - Enabled key fields read back as six zero bytes.
// - Delivery access bytes: key one hidden, key two plain data.
// - Plain-text card: only low four bytes of a block are valid.
// - Plain-text card is accessed without any key login.
// - Large card sectors from thirty-two on span sixteen blocks.
// - Large sectors 20h-27h map from block 80h, login 20h plus four per step.
// - Value is a four-byte two's complement number stored redundantly.
// - Serial number is taken from block zero.
// - Operating-system card must be selected; custom commands go by transfer.
// - After activation application zero counts as selected.
// - Up to 28 applications, 16 files, 14 keys each.
// - File selected before access; secured file needs login first.
// - Changes take effect on commit; abort or power loss discards them.
// - Files use plain, MAC, single DES or triple DES protection.
module ccm_card_memory
  import ccm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic [3:0] req_cmd,
  input wire logic [2:0] req_card,
  input wire logic [7:0] req_sector,
  input wire logic [3:0] req_block,
  input wire logic [5:0] req_key_slot,
  input wire logic [1:0] req_prot,
  input wire logic [47:0] req_key,
  input wire logic [127:0] req_wdata,
  input wire logic field_lost,
  input wire logic card_done,
  input wire logic card_ok,
  input wire logic [127:0] card_rdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [3:0] rsp_err,
  output logic [127:0] rsp_data,
  output logic [55:0] card_uid,
  output logic pending_changes,
  output logic card_go,
  output logic [3:0] card_op,
  output logic [7:0] card_block,
  output logic [7:0] card_login,
  output logic card_auth,
  output logic [47:0] card_key,
  output logic [1:0] card_prot,
  output logic [127:0] card_wdata
);

  // ----------------------------------------------------------------
  // Address mapping
  // ----------------------------------------------------------------
  function automatic logic [7:0] last_block(input logic [2:0] card, input logic [7:0] sec);
    if (card == CARD_LARGE && sec >= BIG_FIRST) begin
      last_block = {4'h0, BIG_BLOCKS};
    end else begin
      last_block = {4'h0, SMALL_BLOCKS};
    end
  endfunction : last_block

  function automatic logic [7:0] abs_block(input logic [2:0] card, input logic [7:0] sec,
                                           input logic [3:0] blk);
    logic [7:0] off;
    off = sec - BIG_FIRST;
    if (card == CARD_PLAIN) begin
      abs_block = sec;
    end else if (card == CARD_LARGE && sec >= BIG_FIRST) begin
      abs_block = BIG_BLOCK_BASE + {off[3:0], blk};
    end else begin
      abs_block = {sec[5:0], blk[1:0]};
    end
  endfunction : abs_block

  function automatic logic sector_ok(input logic [2:0] card, input logic [7:0] sec,
                                     input logic [3:0] blk);
    case (card)
      CARD_STD: sector_ok = sec < STD_SECTORS && {4'h0, blk} <= last_block(card, sec);
      CARD_LARGE: sector_ok = sec <= BIG_LAST && {4'h0, blk} <= last_block(card, sec);
      CARD_PLAIN: sector_ok = sec <= PLAIN_PAGES;
      default: sector_ok = 1'b0;
    endcase
  endfunction : sector_ok

  // ----------------------------------------------------------------
  // Key storage
  // ----------------------------------------------------------------
  logic [47:0] key_mem [KEY_SLOTS];
  logic [47:0] volatile_key_q;

  always_ff @(posedge clk) begin
    if (req_valid && req_ready && req_cmd == CMD_STORE_KEY && req_key_slot < VOLATILE_SLOT) begin
      key_mem[req_key_slot[4:0]] <= req_key;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      volatile_key_q <= 48'h0;
    end else if (req_valid && req_ready && req_cmd == CMD_STORE_KEY
                 && req_key_slot == VOLATILE_SLOT) begin
      volatile_key_q <= req_key;
    end
  end

  // ----------------------------------------------------------------
  // Request check
  // ----------------------------------------------------------------
  ccm_state_e state_q;
  logic os_selected_q, app_active_q, file_sel_q, login_q, pending_q;
  logic [7:0] app_q;
  logic [1:0] file_prot_q;
  logic [3:0] op_q;
  logic [2:0] kind_q;
  logic trailer_q;
  logic [7:0] blk_q;
  logic accept;
  logic [3:0] chk_err;
  logic [7:0] map_blk;
  logic [7:0] map_login;
  logic [7:0] big_off;

  assign accept = req_valid && req_ready;
  assign map_blk = abs_block(req_card, req_sector, req_block);
  assign big_off = req_sector - BIG_FIRST;
  assign map_login = (req_card == CARD_LARGE && req_sector >= BIG_FIRST) ?
                     BIG_FIRST + {big_off[5:0], 2'b00} : req_sector;

  always_comb begin
    chk_err = ERR_NONE;
    case (req_cmd)
      CMD_READ, CMD_WRITE, CMD_READ_VALUE, CMD_WRITE_VALUE: begin
        if (req_card == CARD_OS) begin
          chk_err = os_selected_q ? ERR_COMMAND : ERR_NOT_SELECTED;
        end else if (req_card == CARD_APP) begin
          chk_err = ERR_COMMAND;
        end else if (!sector_ok(req_card, req_sector, req_block)) begin
          chk_err = ERR_RANGE;
        end else if ((req_cmd == CMD_WRITE || req_cmd == CMD_WRITE_VALUE)
                     && map_blk == 8'h00) begin
          chk_err = ERR_READ_ONLY;
        end else if (req_card == CARD_PLAIN && req_cmd != CMD_READ && req_cmd != CMD_WRITE) begin
          chk_err = ERR_COMMAND;
        end
      end
      CMD_STORE_KEY: chk_err = (req_key_slot > VOLATILE_SLOT) ? ERR_RANGE : ERR_NONE;
      CMD_SELECT: chk_err = (req_card == CARD_OS) ? ERR_NONE : ERR_COMMAND;
      CMD_ACTIVATE: chk_err = (req_card == CARD_APP) ? ERR_NONE : ERR_COMMAND;
      CMD_TRANSFER: chk_err = (req_card == CARD_OS && !os_selected_q) ?
                    ERR_NOT_SELECTED : ERR_NONE;
      default: begin
        if (req_card != CARD_APP) begin
          chk_err = ERR_COMMAND;
        end else if (!app_active_q) begin
          chk_err = ERR_NOT_SELECTED;
        end else if ((req_cmd == CMD_SELECT_APP && req_sector >= MAX_APPS)
                     || (req_cmd == CMD_SELECT_FILE && req_block > MAX_FILES)
                     || (req_cmd == CMD_LOGIN && req_key_slot >= MAX_KEYS)) begin
          chk_err = ERR_RANGE;
        end else if (req_cmd == CMD_CHANGE_FILE && !file_sel_q) begin
          chk_err = ERR_NOT_SELECTED;
        end else if (req_cmd == CMD_CHANGE_FILE && file_prot_q != PROT_PLAIN && !login_q) begin
          chk_err = ERR_NO_LOGIN;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer and card request
  // ----------------------------------------------------------------
  logic [31:0] wval;
  assign wval = req_wdata[31:0];

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      req_ready <= 1'b1;
      card_go <= 1'b0;
      card_op <= 4'h0;
      card_block <= 8'h00;
      card_login <= 8'h00;
      card_auth <= 1'b0;
      card_key <= 48'h0;
      card_prot <= PROT_PLAIN;
      card_wdata <= 128'h0;
      op_q <= 4'h0;
      kind_q <= 3'h0;
      trailer_q <= 1'b0;
      blk_q <= 8'h00;
    end else begin
      card_go <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            req_ready <= 1'b0;
            op_q <= req_cmd;
            kind_q <= req_card;
            blk_q <= map_blk;
            trailer_q <= {4'h0, req_block} == last_block(req_card, req_sector)
                         && req_card != CARD_PLAIN;
            if (chk_err != ERR_NONE || req_cmd == CMD_STORE_KEY) begin
              state_q <= ST_RESP;
            end else begin
              state_q <= ST_WAIT;
              card_go <= 1'b1;
              card_block <= req_cmd == CMD_SELECT_APP ? req_sector : map_blk;
              card_login <= map_login;
              card_auth <= req_card == CARD_STD || req_card == CARD_LARGE;
              card_key <= req_key_slot == VOLATILE_SLOT ? volatile_key_q
                                                         : key_mem[req_key_slot[4:0]];
              card_prot <= req_cmd == CMD_CHANGE_FILE ? file_prot_q : req_prot;
              case (req_cmd)
                CMD_READ_VALUE: card_op <= CMD_READ;
                CMD_WRITE_VALUE: card_op <= CMD_WRITE;
                default: card_op <= req_cmd;
              endcase
              if (req_cmd == CMD_WRITE_VALUE) begin
                card_wdata <= {wval, ~wval, wval, map_blk, ~map_blk, map_blk, ~map_blk};
              end else begin
                card_wdata <= req_wdata;
              end
            end
          end
        end
        ST_WAIT: if (card_done) state_q <= ST_RESP;
        ST_RESP: begin
          state_q <= ST_IDLE;
          req_ready <= 1'b1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Answer formatting
  // ----------------------------------------------------------------
  logic [127:0] shaped;
  logic value_bad;

  assign value_bad = card_rdata[127:96] != card_rdata[63:32]
                     || card_rdata[127:96] != ~card_rdata[95:64];

  always_comb begin
    shaped = card_rdata;
    if (op_q == CMD_READ && trailer_q) begin
      shaped[KEY_A_LSB +: 48] = 48'h0;
      // key two is data only under delivery access bytes
      if (card_rdata[ACCESS_LSB +: 24] != ACCESS_DELIVERY) begin
        shaped[KEY_B_LSB +: 48] = 48'h0;
      end
    end
    if (kind_q == CARD_PLAIN) begin
      shaped[127:PLAIN_BITS] = '0;
    end
    if (op_q == CMD_READ_VALUE) begin
      shaped = {96'h0, card_rdata[127:96]};
    end
  end

  // Answer is held in a register so it stands one cycle cleanly with rsp_valid
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_err <= ERR_NONE;
      rsp_data <= 128'h0;
    end else begin
      rsp_valid <= 1'b0;
      if (state_q == ST_IDLE && accept && (chk_err != ERR_NONE || req_cmd == CMD_STORE_KEY)) begin
        rsp_valid <= 1'b1;
        rsp_err <= chk_err;
        rsp_data <= 128'h0;
      end else if (state_q == ST_WAIT && card_done) begin
        rsp_valid <= 1'b1;
        rsp_data <= card_ok ? shaped : 128'h0;
        if (!card_ok) begin
          rsp_err <= ERR_CARD;
        end else if (op_q == CMD_READ_VALUE && value_bad) begin
          rsp_err <= ERR_VALUE;
        end else begin
          rsp_err <= ERR_NONE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Card session state
  // ----------------------------------------------------------------
  logic done_ok;
  assign done_ok = state_q == ST_WAIT && card_done && card_ok;

  always_ff @(posedge clk) begin
    if (reset) begin
      card_uid <= '0;
    end else if (done_ok && op_q == CMD_READ && blk_q == 8'h00
                 && (kind_q == CARD_STD || kind_q == CARD_LARGE)) begin
      card_uid <= {24'h0, card_rdata[127:96]};
    end else if (done_ok && op_q == CMD_ACTIVATE) begin
      card_uid <= card_rdata[127 -: UID_BITS];
    end
  end

  always_ff @(posedge clk) begin
    if (reset || field_lost) begin
      os_selected_q <= 1'b0;
    end else if (done_ok && op_q == CMD_SELECT) begin
      os_selected_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || field_lost) begin
      app_active_q <= 1'b0;
      app_q <= 8'h00;
      file_sel_q <= 1'b0;
      file_prot_q <= PROT_PLAIN;
      login_q <= 1'b0;
    end else if (done_ok) begin
      case (op_q)
        CMD_ACTIVATE: begin
          app_active_q <= 1'b1;
          app_q <= 8'h00;
          file_sel_q <= 1'b0;
          login_q <= 1'b0;
        end
        CMD_SELECT_APP: begin
          app_q <= card_block;
          file_sel_q <= 1'b0;
          login_q <= 1'b0;
        end
        CMD_SELECT_FILE: begin
          file_sel_q <= 1'b1;
          file_prot_q <= card_prot;
        end
        CMD_LOGIN: login_q <= 1'b1;
        default: login_q <= login_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset || field_lost) begin
      pending_q <= 1'b0;
    end else if (done_ok && op_q == CMD_CHANGE_FILE) begin
      pending_q <= 1'b1;
    end else if (state_q == ST_WAIT && card_done && (op_q == CMD_COMMIT || op_q == CMD_ABORT
                 || op_q == CMD_SELECT_APP || op_q == CMD_ACTIVATE)) begin
      pending_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pending_changes <= 1'b0;
    end else begin
      pending_changes <= pending_q;
    end
  end

endmodule : ccm_card_memory

`default_nettype wire

// file: sim/ccm_props.sv
`timescale 1ns/1ps
`default_nettype none
module ccm_props
  import ccm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic [3:0] req_cmd,
  input wire logic [2:0] req_card,
  input wire logic [7:0] req_sector,
  input wire logic [3:0] req_block,
  input wire logic [5:0] req_key_slot,
  input wire logic field_lost,
  input wire logic card_done,
  input wire logic card_ok,
  input wire logic [127:0] card_rdata,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [3:0] rsp_err,
  input wire logic [127:0] rsp_data,
  input wire logic [55:0] card_uid,
  input wire logic pending_changes,
  input wire logic card_go,
  input wire logic [7:0] card_block,
  input wire logic [7:0] card_login,
  input wire logic card_auth
);
  // ----------------------------------------
  // Request capture
  // ----------------------------------------
  logic busy_q, plain_q, trl_q, uid_q;
  logic [7:0] sec_q;
  logic [3:0] blk_q;
  logic [127:0] rd_q;
  wire logic acc = req_valid && req_ready;
  wire logic rd = acc && req_cmd == CMD_READ;
  wire logic fin = busy_q && card_done && card_ok;
  always_ff @(posedge clk) begin
    rd_q <= card_rdata;
    sec_q <= acc ? req_sector : sec_q;
    blk_q <= acc ? req_block : blk_q;
    if (reset) begin
      busy_q <= 1'b0;
      plain_q <= 1'b0;
      trl_q <= 1'b0;
      uid_q <= 1'b0;
    end else begin
      busy_q <= card_go || (busy_q && !card_done);
      if (acc) begin
        plain_q <= rd && req_card == CARD_PLAIN;
        trl_q <= rd && req_card == CARD_STD && req_block == 4'h3;
        uid_q <= rd && req_card == CARD_STD && req_sector == 8'h00 && req_block == 4'h0;
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_std_block_map: assert property (
    rd && req_card == CARD_STD && req_sector < 8'h10 && req_block < 4'h4 |=> card_go && card_auth
    && card_block == {sec_q[5:0], blk_q[1:0]} && card_login == sec_q) else $error("std map");
  a_std_range: assert property (
    rd && req_card == CARD_STD && req_sector > 8'h0f |=> rsp_valid && rsp_err == ERR_RANGE
    && !card_go) else $error("std range");
  a_block0_locked: assert property (
    acc && req_cmd == CMD_WRITE && req_card == CARD_STD && req_sector == 8'h00
    && req_block == 4'h0 |=> rsp_valid && rsp_err == ERR_READ_ONLY && !card_go)
    else $error("block zero written");
  a_big_map: assert property (
    rd && req_card == CARD_LARGE && req_sector >= 8'h20 && req_sector <= 8'h27 |=> card_go
    && card_block == 8'h80 + {1'b0, sec_q[2:0], 4'h0} + {4'h0, blk_q}
    && card_login == 8'h20 + {3'h0, sec_q[2:0], 2'h0}) else $error("large map");
  a_plain_noauth: assert property (
    rd && req_card == CARD_PLAIN |=> card_go && !card_auth) else $error("plain login");
  a_plain_low: assert property (
    fin && plain_q |=> rsp_valid && rsp_data[127:32] == 96'h0) else $error("plain upper");
  a_trailer_hide: assert property (
    fin && trl_q |=> rsp_valid && rsp_data[127:80] == 48'h0) else $error("key one shown");
  a_delivery_data: assert property (
    fin && trl_q && card_rdata[79:56] == 24'hff0780 |=> rsp_data[47:0] == rd_q[47:0])
    else $error("key two data");
  a_uid_take: assert property (
    fin && uid_q |=> card_uid == {24'h0, rd_q[127:96]}) else $error("uid");
  a_key_store: assert property (
    acc && req_cmd == CMD_STORE_KEY && req_key_slot <= 6'h20 |=> rsp_valid
    && rsp_err == ERR_NONE && !card_go) else $error("key store");
  a_key_range: assert property (
    acc && req_cmd == CMD_STORE_KEY && req_key_slot > 6'h20 |=> rsp_valid
    && rsp_err == ERR_RANGE) else $error("key slot range");
  a_power_loss: assert property (
    field_lost [*3] |-> !pending_changes) else $error("pending kept");
endmodule : ccm_props
bind ccm_card_memory ccm_props u_props (.clk(clk), .reset(reset), .req_valid(req_valid),
  .req_cmd(req_cmd), .req_card(req_card), .req_sector(req_sector), .req_block(req_block),
  .req_key_slot(req_key_slot), .field_lost(field_lost), .card_done(card_done),
  .card_ok(card_ok), .card_rdata(card_rdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp_err(rsp_err), .rsp_data(rsp_data), .card_uid(card_uid),
  .pending_changes(pending_changes), .card_go(card_go), .card_block(card_block),
  .card_login(card_login), .card_auth(card_auth));
`default_nettype wire

// file: sim/ccm_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccm_card_model
  import ccm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic card_go,
  input wire logic [3:0] card_op,
  input wire logic [7:0] card_block,
  input wire logic [127:0] card_wdata,
  output logic card_done,
  output logic card_ok,
  output logic [127:0] card_rdata
);
  // Known fill so that reads can be predicted; waits of 1 to 40 cycles mix prompt and slow
  logic [127:0] mem [256];
  int wait_n;
  initial begin
    card_done = 1'b0;
    card_ok = 1'b1;
    card_rdata = '0;
    for (int i = 0; i < 256; i++) mem[i] = {16{8'(i) ^ 8'ha5}};
  end
  always @(posedge clk) begin
    card_done <= 1'b0;
    if (reset) begin
      wait_n <= 0;
      card_rdata <= '0;
    end else if (card_go === 1'b1) begin
      wait_n <= $urandom_range(40, 1);
    end else if (wait_n == 1) begin
      wait_n <= 0;
      card_done <= 1'b1;
      card_rdata <= mem[card_block];
      if (card_op == CMD_WRITE) mem[card_block] <= card_wdata;
    end else begin
      // Read data is only good with the done pulse, so it is scrambled otherwise
      wait_n <= (wait_n > 0) ? wait_n - 1 : 0;
      card_rdata <= ~card_rdata;
    end
  end
endmodule : ccm_card_model
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top
  import ccm_pkg::*;
;
  typedef struct packed {logic [3:0] err; logic [127:0] data; logic [127:0] mask;} ccm_note_s;
  logic clk, reset, req_valid, field_lost, card_done, card_ok, req_ready, rsp_valid;
  logic pending_changes, card_go, card_auth;
  logic [3:0] req_cmd, req_block, rsp_err, card_op, b;
  logic [2:0] req_card;
  logic [7:0] req_sector, card_block, card_login;
  logic [5:0] req_key_slot;
  logic [1:0] req_prot, card_prot;
  logic [47:0] req_key, card_key, k1, k2;
  logic [127:0] req_wdata, card_rdata, rsp_data, card_wdata, w;
  logic [55:0] card_uid;
  logic [31:0] v;
  int fail_count, cmp_count, go_n, g;
  ccm_note_s q[$];
  ccm_card_memory u_ccm_card_memory (.clk(clk), .reset(reset), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_card(req_card), .req_sector(req_sector), .req_block(req_block),
    .req_key_slot(req_key_slot), .req_prot(req_prot), .req_key(req_key),
    .req_wdata(req_wdata), .field_lost(field_lost), .card_done(card_done), .card_ok(card_ok),
    .card_rdata(card_rdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_data(rsp_data), .card_uid(card_uid), .pending_changes(pending_changes),
    .card_go(card_go), .card_op(card_op), .card_block(card_block), .card_login(card_login),
    .card_auth(card_auth), .card_key(card_key), .card_prot(card_prot),
    .card_wdata(card_wdata));
  ccm_card_model u_ccm_card_model (.clk(clk), .reset(reset), .card_go(card_go),
    .card_op(card_op), .card_block(card_block), .card_wdata(card_wdata),
    .card_done(card_done), .card_ok(card_ok), .card_rdata(card_rdata));
  always #12.5 clk = ~clk;
  // ----------------------------------------
  // Result watcher and drivers
  // ----------------------------------------
  always @(negedge clk) begin
    if (card_go === 1'b1) go_n++;
    if (rsp_valid === 1'b1) begin
      ccm_note_s n;
      n = q.pop_front();
      `CHK("rsp_err", n.err, rsp_err)
      `CHK("rsp_data", n.data & n.mask, rsp_data & n.mask)
    end
  end
  function automatic logic [127:0] pat(input logic [7:0] blk);
    return {16{blk ^ 8'ha5}};
  endfunction : pat
  task automatic op(input logic [3:0] cmd, input logic [2:0] card, input logic [7:0] sec,
      input logic [3:0] blk, input logic [3:0] err, input logic [127:0] data = '0,
      input logic [127:0] mask = '0, input logic [127:0] wd = '0,
      input logic [5:0] slot = '0, input logic [1:0] prot = '0);
    int n;
    q.push_back('{err, data, mask});
    @(posedge clk);
    req_valid <= 1'b1;
    req_cmd <= cmd;
    req_card <= card;
    req_sector <= sec;
    req_block <= blk;
    req_wdata <= wd;
    req_key_slot <= slot;
    req_prot <= prot;
    req_key <= 48'({$urandom(), $urandom()});
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    if (n >= 100) fail_count++;
  endtask : op
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {clk, req_valid, field_lost, req_cmd, req_card, req_sector, req_block} = '0;
    {req_key_slot, req_prot, req_key, req_wdata} = '0;
    reset = 1'b1;
    void'($urandom(32'ha1fa673d));
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int s = 0; s < 16; s += 5) begin
      op(CMD_READ, CARD_STD, 8'(s), 4'h2, ERR_NONE, pat(8'(s * 4 + 2)), '1);
      `CHK("card_block", 8'(s * 4 + 2), card_block)
    end
    tend("std map");
    g = go_n;
    op(CMD_WRITE, CARD_STD, 8'h00, 4'h0, ERR_READ_ONLY);
    op(CMD_WRITE_VALUE, CARD_STD, 8'h00, 4'h0, ERR_READ_ONLY);
    op(CMD_READ, CARD_STD, 8'h10, 4'h0, ERR_RANGE);
    op(CMD_READ, CARD_STD, 8'h01, 4'h4, ERR_RANGE);
    op(CMD_READ, CARD_LARGE, 8'h28, 4'h0, ERR_RANGE);
    for (int s = 31; s < 34; s++) op(CMD_STORE_KEY, CARD_STD, 0, 0, s > 32 ? ERR_RANGE : ERR_NONE,
      '0, '0, '0, 6'(s));
    `CHK("card_go count", g, go_n)
    tend("refusals");
    k1 = 48'({$urandom(), $urandom()});
    k2 = 48'({$urandom(), $urandom()});
    op(CMD_WRITE, CARD_STD, 8'h02, 4'h3, ERR_NONE, '0, '0, {k1, 32'hff078069, k2});
    op(CMD_READ, CARD_STD, 8'h02, 4'h3, ERR_NONE, {48'h0, 32'hff078069, k2}, '1);
    op(CMD_WRITE, CARD_STD, 8'h02, 4'h3, ERR_NONE, '0, '0, {k1, 32'h7f078869, k2});
    op(CMD_READ, CARD_STD, 8'h02, 4'h3, ERR_NONE, {48'h0, 32'h7f078869, 48'h0}, '1);
    tend("trailer");
    w = {$urandom(), $urandom(), $urandom(), $urandom()};
    op(CMD_WRITE, CARD_PLAIN, 8'h05, 4'h0, ERR_NONE, '0, '0, w);
    op(CMD_READ, CARD_PLAIN, 8'h05, 4'h0, ERR_NONE, {96'h0, w[31:0]}, '1);
    `CHK("card_auth", 1'b0, card_auth)
    tend("plain");
    for (int s = 31; s < 40; s++) begin
      b = 4'($urandom_range(15));
      g = (s < 32) ? 124 + b % 4 : 128 + (s - 32) * 16 + b;
      w = pat(8'(g));
      if (s < 32 ? b % 4 == 3 : b == 15) w = {48'h0, w[79:48], 48'h0};
      op(CMD_READ, CARD_LARGE, 8'(s), s < 32 ? b % 4 : b, ERR_NONE, w, '1);
      `CHK("card_block", 8'(g), card_block)
      `CHK("card_login", 8'(s < 32 ? s : 32 + (s - 32) * 4), card_login)
    end
    tend("large");
    v = $urandom();
    op(CMD_WRITE_VALUE, CARD_STD, 8'h04, 4'h1, ERR_NONE, '0, '0, {96'h0, v});
    `CHK("value layout", {v, ~v, v}, card_wdata[127:32])
    op(CMD_READ_VALUE, CARD_STD, 8'h04, 4'h1, ERR_NONE, {96'h0, v}, 128'hffffffff);
    op(CMD_READ_VALUE, CARD_STD, 8'h04, 4'h2, ERR_VALUE);
    op(CMD_READ, CARD_STD, 8'h00, 4'h0, ERR_NONE, pat(8'h00), '1);
    `CHK("card_uid", {24'h0, {4{8'ha5}}}, card_uid)
    tend("value and serial");
    op(CMD_TRANSFER, CARD_OS, 0, 0, ERR_NOT_SELECTED);
    op(CMD_SELECT, CARD_OS, 0, 0, ERR_NONE);
    op(CMD_TRANSFER, CARD_OS, 0, 0, ERR_NONE);
    `CHK("card_op", CMD_TRANSFER, card_op)
    tend("os card");
    op(CMD_CHANGE_FILE, CARD_APP, 0, 0, ERR_NOT_SELECTED);
    op(CMD_ACTIVATE, CARD_APP, 0, 0, ERR_NONE);
    for (int p = 0; p < 4; p++) begin
      op(CMD_SELECT_FILE, CARD_APP, 0, 4'(p), ERR_NONE, '0, '0, '0, 0, 2'(p));
      op(CMD_CHANGE_FILE, CARD_APP, 0, 0, p == 0 ? ERR_NONE : ERR_NO_LOGIN);
    end
    op(CMD_LOGIN, CARD_APP, 0, 0, ERR_RANGE, '0, '0, '0, 6'h0e);
    op(CMD_LOGIN, CARD_APP, 0, 0, ERR_NONE, '0, '0, '0, 6'h0d);
    op(CMD_CHANGE_FILE, CARD_APP, 0, 0, ERR_NONE);
    `CHK("card_prot", PROT_TDES, card_prot)
    `CHK("pending", 1'b1, pending_changes)
    op(CMD_ABORT, CARD_APP, 0, 0, ERR_NONE);
    `CHK("pending", 1'b0, pending_changes)
    op(CMD_SELECT_APP, CARD_APP, 8'h1c, 0, ERR_RANGE);
    op(CMD_SELECT_APP, CARD_APP, 8'h1b, 0, ERR_NONE);
    `CHK("card_block", 8'h1b, card_block)
    op(CMD_CHANGE_FILE, CARD_APP, 0, 0, ERR_NOT_SELECTED);
    op(CMD_SELECT_FILE, CARD_APP, 0, 4'hf, ERR_NONE);
    op(CMD_CHANGE_FILE, CARD_APP, 0, 0, ERR_NONE);
    op(CMD_COMMIT, CARD_APP, 0, 0, ERR_NONE);
    `CHK("pending", 1'b0, pending_changes)
    op(CMD_CHANGE_FILE, CARD_APP, 0, 0, ERR_NONE);
    @(posedge clk);
    field_lost <= 1'b1;
    repeat (3) @(posedge clk);
    field_lost <= 1'b0;
    #1;
    `CHK("pending", 1'b0, pending_changes)
    op(CMD_CHANGE_FILE, CARD_APP, 0, 0, ERR_NOT_SELECTED);
    tend("app card");
    `CHK("open notes", 0, q.size())
    close_out();
  end
endmodule : tb_top
`default_nettype wire
